/* pkg/tmr_regs.svh */
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH

// register byte offsets
`define OFS_CTRL 5'h00
`define OFS_CMP_A 5'h04
`define OFS_CAP_B 5'h08
`define OFS_POWER 5'h0C
`define OFS_STATUS 5'h10

// control register field positions
`define CTL_MODE_LO 0
`define CTL_CLK_LO 2
`define CTL_START_LO 4
`define CTL_ACAP 6
`define CTL_TSTOP 7
`define CTL_CEDGE 8
`define CTL_DVTAP 9
`define CTL_WIDTH 10

// power register field positions
`define PWR_LOW_SPEED 0
`define PWR_STOP 1

// reset values
`define CTRL_RESET 10'h000
`define CMP_RESET 16'hFFFF
`define CAP_RESET 16'h0000

// noise filter, in periods of the high speed clock
`define FILT_REJECT_FC 4
`define FILT_DETECT_FC 12
`define FILT_CYCLES ((`FILT_REJECT_FC + `FILT_DETECT_FC) / 2)

`endif

/* pkg/tmr_pkg.sv */
package tmr_pkg;

  typedef enum logic [1:0] {
    MODE_TIMER = 2'h0,
    MODE_WINDOW = 2'h1,
    MODE_PULSE = 2'h2,
    MODE_PPG = 2'h3
  } mode_t;

  typedef enum logic [1:0] {
    START_STOP = 2'h0,
    START_CMD = 2'h1,
    START_RISE = 2'h2,
    START_FALL = 2'h3
  } start_t;

  typedef enum logic [1:0] {
    CLK_SLOW = 2'h0,
    CLK_DIV7 = 2'h1,
    CLK_DIV3 = 2'h2,
    CLK_PIN = 2'h3
  } clk_sel_t;

  typedef struct packed {
    logic divider_tap_select;
    logic capture_edge_mode;
    logic trigger_stop_select;
    logic auto_capture_enable;
    start_t start_control_field;
    clk_sel_t source_clock_select;
    mode_t operating_mode_field;
  } counter_control_reg_t;

  typedef enum logic {
    ST_WAIT = 1'b0,
    ST_RUN = 1'b1
  } run_state_t;

endpackage

/* hw/multi_mode_timer_counter.sv */
`include "tmr_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module multi_mode_timer_counter
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic counter_input_pin,
  input wire logic low_speed_clock,
  output logic match_capture_irq
);
  import tmr_pkg::*;

  localparam logic [3:0] FILT_LAST = 4'(`FILT_CYCLES - 1);

  counter_control_reg_t ctrl_q;
  logic [15:0] cmp_q;
  logic [15:0] cap_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [15:0] cap_d;
  logic low_speed_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic irq_q;
  logic irq_d;
  logic force_stop;
  run_state_t run_q;
  run_state_t run_d;

  // bus slave: one wait state, answer at the second edge
  wire req = read | write;
  wire bus_we = write & ack_q;
  wire sel_ctrl = address == `OFS_CTRL;
  wire sel_cmp = address == `OFS_CMP_A;
  wire sel_cap = address == `OFS_CAP_B;
  wire sel_pwr = address == `OFS_POWER;
  wire sel_stat = address == `OFS_STATUS;
  wire we_ctrl = bus_we & sel_ctrl & byteenable[0];
  wire we_ctrl_hi = bus_we & sel_ctrl & byteenable[1];
  wire we_cmp_lo = bus_we & sel_cmp & byteenable[0];
  wire we_cmp_hi = bus_we & sel_cmp & byteenable[1];
  wire we_pwr = bus_we & sel_pwr & byteenable[0];
  assign waitrequest = req & ~ack_q;

  logic [31:0] rmux;
  logic pin_lvl_q;
  assign rmux =
    sel_ctrl ? {22'h0, ctrl_q} :
    sel_cmp ? {16'h0, cmp_q} :
    sel_cap ? {16'h0, cap_q} :
    sel_pwr ? {31'h0, low_speed_q} :
    sel_stat ? {30'h0, pin_lvl_q, run_q == ST_RUN} :
    32'h0;

  always_ff @(posedge clk)
  begin
    if (rst)
      ack_q <= 1'b0;
    else
      ack_q <= req & ~ack_q;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_q <= 32'h0;
    else if (read & ~ack_q)
      rdata_q <= rmux;
  end
  assign readdata = rdata_q;

  // writing the stop bit models entry to the stop power mode
  assign force_stop = we_pwr & writedata[`PWR_STOP];

  always_ff @(posedge clk)
  begin
    if (rst)
      ctrl_q <= counter_control_reg_t'(`CTRL_RESET);
    else
    begin
      if (we_ctrl)
        ctrl_q[7:0] <= writedata[7:0];
      if (we_ctrl_hi)
        ctrl_q[9:8] <= writedata[9:8];
      if (force_stop)
        ctrl_q.start_control_field <= START_STOP;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cmp_q <= `CMP_RESET;
      low_speed_q <= 1'b0;
    end
    else
    begin
      if (we_cmp_lo)
        cmp_q[7:0] <= writedata[7:0];
      if (we_cmp_hi)
        cmp_q[15:8] <= writedata[15:8];
      if (we_pwr)
        low_speed_q <= writedata[`PWR_LOW_SPEED];
    end
  end

  // prescaler of the high speed clock
  logic [10:0] pre_q;
  logic [2:0] fs_s_q;
  logic fs_lvl_q;
  logic [2:0] fs_div_q;
  always_ff @(posedge clk)
  begin
    if (rst)
      pre_q <= 11'h000;
    else
      pre_q <= pre_q + 11'h001;
  end

  // low speed clock is asynchronous: three flops, second and third agree
  wire fs_agree = fs_s_q[1] == fs_s_q[2];
  wire fs_rise = fs_agree & fs_s_q[2] & ~fs_lvl_q;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fs_s_q <= 3'h0;
      fs_lvl_q <= 1'b0;
      fs_div_q <= 3'h0;
    end
    else
    begin
      fs_s_q <= {fs_s_q[1:0], low_speed_clock};
      if (fs_agree)
        fs_lvl_q <= fs_s_q[2];
      if (fs_rise)
        fs_div_q <= fs_div_q + 3'h1;
    end
  end

  wire tick_d3 = pre_q[2:0] == 3'h7;
  wire tick_d7 = pre_q[6:0] == 7'h7F;
  wire tick_d11 = pre_q == 11'h7FF;
  wire tick_fs3 = fs_rise & (fs_div_q == 3'h7);
  wire use_fs = low_speed_q | ctrl_q.divider_tap_select;

  // in low speed mode only the slowest tap exists
  logic src_tick;
  assign src_tick =
    (ctrl_q.source_clock_select == CLK_SLOW) ?
      (use_fs ? tick_fs3 : tick_d11) :
    low_speed_q ? 1'b0 :
    (ctrl_q.source_clock_select == CLK_DIV7) ? tick_d7 :
    (ctrl_q.source_clock_select == CLK_DIV3) ? tick_d3 :
    1'b0;

  // input pin: three flops, then a stability filter that low speed mode bypasses
  logic [2:0] pin_s_q;
  logic [3:0] filt_q;
  logic pin_lvl_d;
  wire pin_agree = pin_s_q[1] == pin_s_q[2];
  wire pin_diff = pin_agree & (pin_s_q[2] != pin_lvl_q);
  // filter length sits between the reject and detect widths
  wire filt_done = filt_q == FILT_LAST;
  assign pin_lvl_d =
    (pin_diff & (low_speed_q | filt_done)) ? pin_s_q[2] :
    pin_lvl_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pin_s_q <= 3'h0;
      filt_q <= 4'h0;
      pin_lvl_q <= 1'b0;
    end
    else
    begin
      pin_s_q <= {pin_s_q[1:0], counter_input_pin};
      filt_q <= (pin_diff & ~filt_done) ? filt_q + 4'h1 : 4'h0;
      pin_lvl_q <= pin_lvl_d;
    end
  end

  wire pin_rise = pin_lvl_d & ~pin_lvl_q;
  wire pin_fall = ~pin_lvl_d & pin_lvl_q;

  // decode of mode and start fields
  start_t st;
  assign st = ctrl_q.start_control_field;
  wire stopped = st == START_STOP;
  wire edge_sel = st == START_RISE || st == START_FALL;
  wire trig_edge = (st == START_FALL) ? pin_fall : pin_rise;
  wire opp_edge = (st == START_FALL) ? pin_rise : pin_fall;
  wire ext_src = ctrl_q.source_clock_select == CLK_PIN;
  wire m_basic = ctrl_q.operating_mode_field == MODE_TIMER;
  wire m_event = m_basic & ext_src;
  wire m_timer = m_basic & ~ext_src & (st == START_CMD);
  wire m_trig = m_basic & ~ext_src & edge_sel;
  wire m_window = ctrl_q.operating_mode_field == MODE_WINDOW;
  wire m_pulse = (ctrl_q.operating_mode_field == MODE_PULSE) & edge_sel;
  wire gate_open = (st == START_FALL) ? ~pin_lvl_q : pin_lvl_q;
  wire [15:0] cnt_inc = cnt_q + 16'h0001;
  wire inc_match = cnt_inc == cmp_q;
  wire cur_match = cnt_q == cmp_q;
  wire cap_allowed = m_timer | m_event | m_window;
  wire cnt_tick = m_event ? (edge_sel ? trig_edge : pin_rise) : src_tick;

  always_comb
  begin
    cnt_d = cnt_q;
    cap_d = cap_q;
    irq_d = 1'b0;
    run_d = run_q;
    if (stopped)
    begin
      cnt_d = 16'h0000;
      run_d = ST_WAIT;
    end
    else if (m_timer)
    begin
      if (src_tick)
        cnt_d = inc_match ? 16'h0000 : cnt_inc;
      irq_d = src_tick & inc_match;
    end
    else if (m_event)
    begin
      if (cnt_tick)
        cnt_d = cnt_inc;
      else if (opp_edge & cur_match)
      begin
        cnt_d = 16'h0000;
        irq_d = 1'b1;
      end
    end
    else if (m_window)
    begin
      if (src_tick & gate_open)
      begin
        cnt_d = inc_match ? 16'h0000 : cnt_inc;
        irq_d = inc_match;
      end
    end
    else if (m_trig)
    begin
      case (run_q)
        ST_WAIT:
        begin
          if (trig_edge)
          begin
            run_d = ST_RUN;
            cnt_d = 16'h0000;
          end
        end
        ST_RUN:
        begin
          if (ctrl_q.trigger_stop_select & opp_edge)
          begin
            run_d = ST_WAIT;
            cnt_d = 16'h0000;
          end
          else if (src_tick)
          begin
            if (inc_match)
            begin
              run_d = ST_WAIT;
              cnt_d = 16'h0000;
              irq_d = 1'b1;
            end
            else
              cnt_d = cnt_inc;
          end
        end
        default: run_d = ST_WAIT;
      endcase
    end
    else if (m_pulse)
    begin
      case (run_q)
        ST_WAIT:
        begin
          // single-edge holds at one until a trigger restarts it
          if (trig_edge)
            run_d = ST_RUN;
        end
        ST_RUN:
        begin
          if (opp_edge)
          begin
            cap_d = cnt_q;
            irq_d = 1'b1;
            if (ctrl_q.capture_edge_mode)
            begin
              cnt_d = 16'h0001;
              run_d = ST_WAIT;
            end
            else if (src_tick)
              cnt_d = cnt_inc;
          end
          else if (trig_edge & ~ctrl_q.capture_edge_mode)
          begin
            cap_d = cnt_q;
            irq_d = 1'b1;
            cnt_d = 16'h0000;
          end
          else if (src_tick)
            cnt_d = cnt_inc;
        end
        default: run_d = ST_WAIT;
      endcase
    end
    // auto-capture follows the counter's own source clock
    if (ctrl_q.auto_capture_enable & cap_allowed & ~stopped & cnt_tick)
      cap_d = cnt_q;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_q <= 16'h0000;
      cap_q <= `CAP_RESET;
      irq_q <= 1'b0;
      run_q <= ST_WAIT;
    end
    else
    begin
      cnt_q <= cnt_d;
      cap_q <= cap_d;
      irq_q <= irq_d;
      run_q <= run_d;
    end
  end

  assign match_capture_irq = irq_q;

endmodule

`default_nettype wire

/* dv/tmr_asserts.sv */
`include "tmr_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tmr_asserts
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic counter_input_pin,
  input wire logic low_speed_clock,
  input wire logic match_capture_irq
);
  logic [4:0] stab_q;
  logic pin_q;
  wire taken = read && !waitrequest;
  // counts quiet cycles of the raw pin, so filter latency is covered
  always_ff @(posedge clk)
  begin
    pin_q <= counter_input_pin;
    if (rst || pin_q != counter_input_pin)
      stab_q <= 5'h00;
    else if (stab_q != 5'h1F)
      stab_q <= stab_q + 5'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wait_state_a: assert property ($rose(read) |-> waitrequest)
    else $error("read answered without wait state");
  answer_next_a: assert property ((read || write) && waitrequest
    |=> !waitrequest) else $error("bus answer late");
  read_hold_a: assert property (!read |=> $stable(readdata))
    else $error("readdata moved without read");
  unmapped_zero_a: assert property (taken && address == 5'h14
    |-> readdata == 32'h0) else $error("unmapped read not zero");
  upper_zero_a: assert property (taken && address == `OFS_CMP_A
    |-> readdata[31:16] == 16'h0) else $error("compare wider than 16");
  pin_sync_a: assert property (taken && address == `OFS_STATUS
    && stab_q > 5'h17 |-> readdata[1] == counter_input_pin)
    else $error("filtered pin wrong");
  stop_quiet_a: assert property (write && !waitrequest
    && address == `OFS_POWER && writedata[1] && byteenable[0]
    |-> ##3 !match_capture_irq [*6]) else $error("irq after stop");
  irq_pulse_a: assert property (match_capture_irq
    |=> !match_capture_irq) else $error("irq longer than a cycle");
endmodule
bind multi_mode_timer_counter tmr_asserts chk (.clk(clk), .rst(rst),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .counter_input_pin(counter_input_pin),
  .low_speed_clock(low_speed_clock),
  .match_capture_irq(match_capture_irq));
`default_nettype wire

/* dv/pin_source.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_source
(
  input wire logic clk,
  input wire logic want,
  input wire logic glitch,
  output logic pin,
  output logic fs_clk
);
  logic lvl_q;
  logic [3:0] held_q;
  logic [2:0] div_q;
  initial
  begin
    lvl_q = 1'b0;
    held_q = 4'h0;
    div_q = 3'h0;
    fs_clk = 1'b0;
  end
  // glitch is a deliberate short blip, only when a test asks for it
  assign pin = lvl_q ^ glitch;
  always @(posedge clk)
  begin
    div_q <= div_q + 3'h1;
    if (div_q == 3'h7)
      fs_clk <= ~fs_clk;
    // each level stands 16 cycles at least, so gating stays slow
    if (want != lvl_q && held_q == 4'hF)
    begin
      lvl_q <= want;
      held_q <= 4'h0;
    end
    else if (held_q != 4'hF)
      held_q <= held_q + 4'h1;
  end
endmodule
`default_nettype wire

/* dv/tb.sv */
`include "tmr_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0;
  logic want = 1'b0, glitch = 1'b0, pin, fs, irq;
  logic [4:0] address = 5'h00;
  logic [31:0] writedata = 32'h0, readdata, q, p;
  logic [3:0] byteenable = 4'h0;
  logic waitrequest;
  int failures = 0, comparisons = 0, irq_n = 0, t;
  always #12.5 clk = ~clk;
  always @(posedge clk)
    if (irq === 1'b1)
      irq_n <= irq_n + 1;
  pin_source src (.clk(clk), .want(want), .glitch(glitch), .pin(pin),
    .fs_clk(fs));
  multi_mode_timer_counter dut (.clk(clk), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .counter_input_pin(pin),
    .low_speed_clock(fs), .match_capture_irq(irq));
  task automatic check(input string n, input logic [31:0] s, e);
    comparisons++;
    if (s !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a,
    input logic [31:0] d);
    write <= w;
    read <= !w;
    address <= a;
    writedata <= d;
    byteenable <= 4'hF;
    @(posedge clk);
    while (waitrequest !== 1'b0)
      @(posedge clk);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(input int hi, lo);
    want <= 1'b1;
    repeat (hi) @(posedge clk);
    want <= 1'b0;
    repeat (lo) @(posedge clk);
  endtask
  task automatic wait_irq(output int c);
    c = 0;
    t = irq_n;
    while (irq_n == t && c < 300)
    begin
      @(posedge clk);
      c++;
    end
  endtask
  task automatic reset_values;
    bus(0, `OFS_CTRL, 0); check("ctrl", q, 0);
    bus(0, `OFS_CMP_A, 0); check("cmp", q, 32'hFFFF);
    bus(0, `OFS_CAP_B, 0); check("cap", q, 0);
    bus(0, 5'h14, 0); check("unmapped", q, 0);
  endtask
  task automatic timer_run;
    int c;
    bus(1, `OFS_CMP_A, 3);
    bus(1, `OFS_CTRL, 32'h58);
    wait_irq(c);
    wait_irq(c);
    check("period", c, 24);
    bus(0, `OFS_CAP_B, 0);
    check("acap", {31'h0, q < 3}, 1);
    bus(1, `OFS_POWER, 2);
    bus(0, `OFS_CTRL, 0);
    check("stop", {30'h0, q[5:4]}, 0);
    t = irq_n;
    repeat (60) @(posedge clk);
    check("halted", irq_n, t);
    bus(1, `OFS_POWER, 1);
    bus(1, `OFS_CMP_A, 2);
    bus(1, `OFS_CTRL, 32'h10);
    wait_irq(c);
    wait_irq(c);
    check("slow period", c, 256);
    bus(1, `OFS_CTRL, 0);
    bus(1, `OFS_POWER, 0);
  endtask
  task automatic event_run;
    bus(1, `OFS_CMP_A, 2);
    bus(1, `OFS_CTRL, 32'h6C);
    t = irq_n;
    pulse(20, 20);
    glitch <= 1'b1;
    repeat (3) @(posedge clk);
    glitch <= 1'b0;
    pulse(30, 0);
    check("no irq at count", irq_n, t);
    repeat (30) @(posedge clk);
    check("event irq", irq_n, t + 1);
    bus(0, `OFS_STATUS, 0);
    check("pin low", q[1], 0);
    bus(0, `OFS_CAP_B, 0);
    check("event acap", q, 1);
  endtask
  task automatic trigger_run;
    bus(1, `OFS_CTRL, 0);
    bus(1, `OFS_CMP_A, 100);
    bus(1, `OFS_CTRL, 32'hA8);
    t = irq_n;
    want <= 1'b1;
    repeat (30) @(posedge clk);
    bus(0, `OFS_STATUS, 0); check("run", q[0], 1);
    want <= 1'b0;
    repeat (40) @(posedge clk);
    bus(0, `OFS_STATUS, 0); check("halt", q[0], 0);
    repeat (900) @(posedge clk);
    check("no irq", irq_n, t);
    bus(1, `OFS_CTRL, 0);
    bus(1, `OFS_CMP_A, 8);
    bus(1, `OFS_CTRL, 32'h28);
    pulse(20, 20);
    pulse(20, 160);
    check("one irq", irq_n, t + 1);
  endtask
  task automatic pulse_run;
    bus(1, `OFS_CTRL, 0);
    bus(1, `OFS_CMP_A, 32'hFFFF);
    bus(1, `OFS_CTRL, 32'h12A);
    t = irq_n;
    pulse(80, 40);
    check("cap irq", irq_n, t + 1);
    bus(0, `OFS_CAP_B, 0);
    pulse(80, 40);
    check("cap irq 2", irq_n, t + 2);
    bus(0, `OFS_CAP_B, 0);
    check("width", {31'h0, q >= 10 && q <= 11}, 1);
  endtask
  task automatic period_run;
    bus(1, `OFS_CTRL, 0);
    bus(1, `OFS_CTRL, 32'h3A);
    t = irq_n;
    pulse(40, 80);
    pulse(40, 80);
    check("two irqs", irq_n, t + 2);
    bus(0, `OFS_CAP_B, 0);
    check("cycle", {31'h0, q >= 14 && q <= 15}, 1);
  endtask
  task automatic window_run;
    bus(1, `OFS_CTRL, 0);
    bus(1, `OFS_CTRL, 32'h69);
    repeat (8) @(posedge clk);
    bus(0, `OFS_CAP_B, 0); p = q;
    repeat (80) @(posedge clk);
    bus(0, `OFS_CAP_B, 0);
    check("gate shut", q, p);
    pulse(80, 0);
    bus(0, `OFS_CAP_B, 0);
    check("gate open", {31'h0, q > p}, 1);
  endtask
  task automatic results;
    if (failures == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    reset_values();
    timer_run();
    event_run();
    trigger_run();
    pulse_run();
    period_run();
    window_run();
    results();
  end
  initial
  begin
    #(25 * 8000);
    failures++;
    results();
  end
endmodule
`default_nettype wire
